// ### rtl/sd_cmd_pkg.sv
package sd_cmd_pkg;
  // Register offsets, one word each
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ARG = 8'h04;
  localparam logic [7:0] OFS_RSP01 = 8'h08;
  localparam logic [7:0] OFS_RSP23 = 8'h0c;
  localparam logic [7:0] OFS_RSP45 = 8'h10;
  localparam logic [7:0] OFS_RSP67 = 8'h14;
  localparam logic [7:0] OFS_RSP_INDEX = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  localparam logic [7:0] OFS_BLK_SIZE = 8'h20;
  localparam logic [7:0] OFS_BLK_COUNT = 8'h24;

  // Command register fields
  localparam int CMD_INDEX_LSB = 0;
  localparam int CMD_INDEX_W = 6;
  localparam int PUSH_PULL_BIT = 7;
  localparam int BUSY_BIT = 8;
  localparam int KIND_LSB = 9;
  localparam int KIND_W = 2;
  localparam int DIR_BIT = 11;
  localparam int STREAM_BIT = 12;
  localparam int DATA_BIT = 13;
  localparam logic [31:0] CMD_WR_MASK = 32'h0000_ffbf;

  // Status register fields
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_RSP_DONE_BIT = 1;
  localparam int ST_CRC_ERR_BIT = 2;
  localparam int ST_TIMEOUT_BIT = 3;
  localparam int ST_CARD_BUSY_BIT = 4;
  localparam int ST_DATA_ACTIVE_BIT = 5;
  localparam int ST_CMD_SENT_BIT = 6;

  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [15:0] RESET_HALF = 16'h0000;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Frame layout
  localparam logic [7:0] FRAME_LEN = 8'h30;
  localparam logic [7:0] LONG_LEN = 8'h88;
  localparam logic [7:0] TX_CRC_POS = 8'h28;
  localparam logic [7:0] LONG_CRC_FIRST = 8'h08;
  localparam logic [7:0] LONG_CRC_END = 8'h80;
  localparam logic START_BIT = 1'b0;
  localparam logic XMIT_BIT = 1'b1;
  localparam logic END_BIT = 1'b1;
  localparam int CRC_W = 7;
  localparam int CRC_LSB = 1;
  localparam logic [6:0] CRC_POLY = 7'h09;
  localparam int WORD_W = 16;
  localparam int RSP_WORDS = 8;
  localparam int IDX_LSB_48 = 40;
  localparam int W7_LSB_48 = 24;
  localparam int W6_LSB_48 = 8;
  localparam int IDX_LSB_136 = 128;
  localparam logic [5:0] STOP_CMD_INDEX = 6'h0c;
  localparam logic [15:0] BUSY_SETTLE_CLKS = 16'h0002;

  // Response kinds
  typedef enum logic [1:0] {
    RSP_NONE = 2'h0,
    RSP_48_CRC = 2'h1,
    RSP_136 = 2'h2,
    RSP_48_NOCRC = 2'h3
  } rsp_kind_t;

  // Command engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_TX = 3'h1,
    ST_RSP_WAIT = 3'h2,
    ST_RSP_RX = 3'h3,
    ST_BUSY = 3'h4
  } cmd_state_t;
endpackage : sd_cmd_pkg

// ### rtl/crc7_if.sv
`timescale 1ns/1ns
`default_nettype none
interface crc7_if;
  logic clear;
  logic shift;
  logic din;
  logic [6:0] crc;
  modport engine(output clear, output shift, output din, input crc);
  modport calc(input clear, input shift, input din, output crc);
endinterface : crc7_if
`default_nettype wire

// ### rtl/sd_crc7.sv
`timescale 1ns/1ns
`default_nettype none
module sd_crc7 (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Engine side
  crc7_if.calc crc_io
);
  // Serial CRC7, one bit per shift; clear beats shift
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      crc_io.crc <= 7'h00;
    end else if (crc_io.clear) begin
      crc_io.crc <= 7'h00;
    end else if (crc_io.shift) begin
      crc_io.crc <= {crc_io.crc[5:0], 1'b0} ^ ((crc_io.din ^ crc_io.crc[6]) ? sd_cmd_pkg::CRC_POLY : 7'h00);
    end
  end
endmodule : sd_crc7
`default_nettype wire

// ### rtl/sd_pin_sync.sv
`timescale 1ns/1ns
`default_nettype none
module sd_pin_sync #(
  parameter int WIDTH = 3
) (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Pins
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  // Two flops per pin; stage1 feeds only the second flop
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '0;
      synced <= '0;
    end else begin
      stage1 <= raw;
      synced <= stage1;
    end
  end
endmodule : sd_pin_sync
`default_nettype wire

// ### rtl/sd_command_issue_response.sv
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// RULE1 - Block transfer stops after size times count bytes.
// RULE2 - Stream transfer runs until a stop command.
// RULE3 - Bit 11: 0 reads card, 1 writes card.
// RULE4 - Kind bits 10-9: none, 48-bit, 136-bit, 48-bit.
// RULE5 - CRC checked for kinds 1h, 2h, not 3h.
// RULE6 - Kind 1h with busy bit 8 waits for card busy.
// RULE7 - Bit 7: open-drain (0) or push-pull (1) drive.
// RULE8 - Index bits 5-0 go into the frame.
// RULE9 - 48-bit frame MSB first: start, transmission, index, argument, CRC7, end.
// RULE10 - Command write starts sending; argument loaded first.
// RULE11 - Argument left alone while a command is sent.
// RULE12 - Argument and command registers unchanged after loading.
// RULE13 - Argument high half 31-16, low half 15-0, resets zero.
// RULE14 - Each response overwrites the words at once.
// RULE15 - Responses land in eight 16-bit words.
// RULE16 - First response byte goes to the index register.
// RULE17 - 48-bit response: index, word 7, word 6, low byte of word 5.
// RULE18 - 136-bit response: index, then 16-bit slices, word 7 to 0.
// RULE19 - Stream and direction matter only with the data flag.
// RULE20 - Start bit 0, transmission bit 1, end bit 1.
// RULE21 - CRC7 x^7+x^3+1 over bits 47-8, same check on responses.
module sd_command_issue_response #(
  parameter int RSP_TIMEOUT_CLKS = 64,
  parameter int BUSY_MAX_CLKS = 65535
) (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  // Card link
  input wire logic card_clk,
  input wire logic cmd_in,
  output logic cmd_out,
  output logic cmd_oe,
  input wire logic dat0_in,
  // Data path
  input wire logic data_byte_strobe,
  output logic data_active,
  output logic data_write,
  output logic data_stream
);
  // Software visible state
  logic [31:0] command_issue;
  logic [31:0] command_argument;
  logic [15:0] response_words [sd_cmd_pkg::RSP_WORDS];
  logic [7:0] response_index;
  logic [11:0] block_size;
  logic [15:0] block_count;
  logic rsp_done;
  logic crc_err;
  logic rsp_timeout;
  logic cmd_sent;

  // Engine state
  sd_cmd_pkg::cmd_state_t state;
  logic [7:0] tx_cnt;
  logic [7:0] rx_cnt;
  logic [15:0] wait_cnt;
  logic [47:0] tx_shift;
  logic [135:0] rx_shift;
  logic [27:0] bytes_left;

  // Command options latched at start
  sd_cmd_pkg::rsp_kind_t act_kind;
  logic [5:0] act_index;
  logic act_busy;
  logic act_pp;
  logic act_data;
  logic act_stream;
  logic act_dir;

  // Synchronised pins and edge finding
  logic [2:0] pins_sync;
  logic card_clk_s;
  logic cmd_s;
  logic dat0_s;
  logic card_clk_prev;
  logic card_rise;
  logic card_fall;

  // Decoded helpers
  logic cmd_start;
  logic long_rsp;
  logic [7:0] rx_len;
  logic rx_feed;
  logic rx_last;
  logic [135:0] next_rx;
  logic crc_ok;
  logic tx_bit;
  logic tx_end;
  logic wait_timeout;
  logic busy_end;
  logic busy_timeout;
  logic cmd_done;
  logic [27:0] total_bytes;
  logic [31:0] status_word;

  crc7_if crc_bus ();

  sd_pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .raw({dat0_in, cmd_in, card_clk}),
    .synced(pins_sync)
  );

  sd_crc7 u_crc7 (
    .clk(clk),
    .nrst(nrst),
    .crc_io(crc_bus.calc)
  );

  assign card_clk_s = pins_sync[0];
  assign cmd_s = pins_sync[1];
  assign dat0_s = pins_sync[2];

  // Card clock history, taken after synchronisation
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      card_clk_prev <= 1'b0;
    end else begin
      card_clk_prev <= card_clk_s;
    end
  end

  assign card_rise = card_clk_s & ~card_clk_prev;
  assign card_fall = ~card_clk_s & card_clk_prev;

  // Event decode for the engine
  assign cmd_start = wr_en && (addr == sd_cmd_pkg::OFS_CMD) && (state == sd_cmd_pkg::ST_IDLE); // RULE10
  assign long_rsp = (act_kind == sd_cmd_pkg::RSP_136); // RULE4
  assign rx_len = long_rsp ? sd_cmd_pkg::LONG_LEN : sd_cmd_pkg::FRAME_LEN; // RULE4
  // Long responses leave their first and last byte out of the check
  assign rx_feed = long_rsp ? ((rx_cnt >= sd_cmd_pkg::LONG_CRC_FIRST) && (rx_cnt < sd_cmd_pkg::LONG_CRC_END))
                            : (rx_cnt < sd_cmd_pkg::TX_CRC_POS); // RULE21
  assign next_rx = {rx_shift[134:0], cmd_s};
  assign rx_last = (state == sd_cmd_pkg::ST_RSP_RX) && card_rise && (rx_cnt == rx_len - 8'h01);
  assign crc_ok = (act_kind == sd_cmd_pkg::RSP_48_NOCRC) ||
                  (next_rx[sd_cmd_pkg::CRC_LSB +: sd_cmd_pkg::CRC_W] == crc_bus.crc); // RULE5
  assign tx_bit = (tx_cnt == sd_cmd_pkg::TX_CRC_POS) ? crc_bus.crc[6] : tx_shift[47];
  assign tx_end = (state == sd_cmd_pkg::ST_TX) && card_fall && (tx_cnt == sd_cmd_pkg::FRAME_LEN);
  assign wait_timeout = (state == sd_cmd_pkg::ST_RSP_WAIT) && card_rise && cmd_s &&
                        (wait_cnt == 16'(RSP_TIMEOUT_CLKS - 1));
  assign busy_end = (state == sd_cmd_pkg::ST_BUSY) && card_rise && dat0_s &&
                    (wait_cnt >= sd_cmd_pkg::BUSY_SETTLE_CLKS);
  assign busy_timeout = (state == sd_cmd_pkg::ST_BUSY) && card_rise && !busy_end &&
                        (wait_cnt == 16'(BUSY_MAX_CLKS - 1));
  assign cmd_done = (tx_end && (act_kind == sd_cmd_pkg::RSP_NONE)) ||
                    (rx_last && !(act_busy && (act_kind == sd_cmd_pkg::RSP_48_CRC))) ||
                    busy_end || busy_timeout || wait_timeout;
  assign total_bytes = {16'h0000, block_size} * {12'h000, block_count};

  // CRC steering; one serial CRC serves transmit and receive
  always_comb begin
    crc_bus.clear = 1'b0;
    crc_bus.shift = 1'b0;
    crc_bus.din = 1'b0;
    case (state)
      sd_cmd_pkg::ST_IDLE: begin
        crc_bus.clear = 1'b1;
      end
      sd_cmd_pkg::ST_TX: begin
        if (card_fall && (tx_cnt < sd_cmd_pkg::TX_CRC_POS)) begin
          crc_bus.shift = 1'b1; // RULE21
          crc_bus.din = tx_shift[47];
        end
        if (tx_end) begin
          crc_bus.clear = 1'b1;
        end
      end
      sd_cmd_pkg::ST_RSP_WAIT: begin
        if (card_rise && !cmd_s && !long_rsp) begin
          crc_bus.shift = 1'b1; // RULE21
          crc_bus.din = 1'b0;
        end
      end
      sd_cmd_pkg::ST_RSP_RX: begin
        if (card_rise && rx_feed) begin
          crc_bus.shift = 1'b1; // RULE21
          crc_bus.din = cmd_s;
        end
      end
      default: begin
        crc_bus.clear = 1'b0;
      end
    endcase
  end

  // Command engine: drive on card clock falls, sample on rises
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= sd_cmd_pkg::ST_IDLE;
      tx_cnt <= 8'h00;
      rx_cnt <= 8'h00;
      wait_cnt <= 16'h0000;
      tx_shift <= '0;
      rx_shift <= '0;
      cmd_out <= 1'b0;
      cmd_oe <= 1'b0;
    end else begin
      case (state)
        sd_cmd_pkg::ST_IDLE: begin
          cmd_oe <= 1'b0;
          cmd_out <= 1'b0;
          if (cmd_start) begin
            // Copy only; the registers keep what was written
            tx_shift <= {sd_cmd_pkg::START_BIT, sd_cmd_pkg::XMIT_BIT, wdata[sd_cmd_pkg::CMD_INDEX_LSB +: 6],
                         command_argument, 7'h00, sd_cmd_pkg::END_BIT}; // RULE8 RULE9 RULE12 RULE20
            tx_cnt <= 8'h00;
            state <= sd_cmd_pkg::ST_TX;
          end
        end
        sd_cmd_pkg::ST_TX: begin
          if (card_fall) begin
            if (tx_cnt == sd_cmd_pkg::FRAME_LEN) begin
              cmd_oe <= 1'b0;
              cmd_out <= 1'b0;
              wait_cnt <= 16'h0000;
              state <= (act_kind == sd_cmd_pkg::RSP_NONE) ? sd_cmd_pkg::ST_IDLE : sd_cmd_pkg::ST_RSP_WAIT; // RULE4
            end else begin
              // Open drain only pulls low; the pull-up makes the ones
              cmd_oe <= act_pp ? 1'b1 : ~tx_bit; // RULE7
              cmd_out <= act_pp ? tx_bit : 1'b0; // RULE7
              tx_cnt <= tx_cnt + 8'h01;
              if (tx_cnt == sd_cmd_pkg::TX_CRC_POS) begin
                tx_shift <= {crc_bus.crc[5:0], tx_shift[40:0], 1'b0}; // RULE9 RULE21
              end else begin
                tx_shift <= {tx_shift[46:0], 1'b0}; // RULE9
              end
            end
          end
        end
        sd_cmd_pkg::ST_RSP_WAIT: begin
          if (card_rise) begin
            if (!cmd_s) begin
              rx_shift <= next_rx;
              rx_cnt <= 8'h01;
              state <= sd_cmd_pkg::ST_RSP_RX;
            end else if (wait_timeout) begin
              state <= sd_cmd_pkg::ST_IDLE;
            end else begin
              wait_cnt <= wait_cnt + 16'h0001;
            end
          end
        end
        sd_cmd_pkg::ST_RSP_RX: begin
          if (card_rise) begin
            rx_shift <= next_rx;
            rx_cnt <= rx_cnt + 8'h01;
            if (rx_last) begin
              wait_cnt <= 16'h0000;
              if (act_busy && (act_kind == sd_cmd_pkg::RSP_48_CRC)) begin
                state <= sd_cmd_pkg::ST_BUSY; // RULE6
              end else begin
                state <= sd_cmd_pkg::ST_IDLE;
              end
            end
          end
        end
        sd_cmd_pkg::ST_BUSY: begin
          // Card holds data line 0 low while busy; a short settle skips the gap
          if (card_rise) begin
            if (busy_end || busy_timeout) begin
              state <= sd_cmd_pkg::ST_IDLE; // RULE6
            end else begin
              wait_cnt <= wait_cnt + 16'h0001;
            end
          end
        end
        default: begin
          state <= sd_cmd_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Options latched so a later write cannot disturb a frame
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      act_kind <= sd_cmd_pkg::RSP_NONE;
      act_index <= 6'h00;
      act_busy <= 1'b0;
      act_pp <= 1'b0;
      act_data <= 1'b0;
      act_stream <= 1'b0;
      act_dir <= 1'b0;
    end else if (cmd_start) begin
      act_kind <= sd_cmd_pkg::rsp_kind_t'(wdata[sd_cmd_pkg::KIND_LSB +: sd_cmd_pkg::KIND_W]); // RULE4
      act_index <= wdata[sd_cmd_pkg::CMD_INDEX_LSB +: 6]; // RULE8
      act_busy <= wdata[sd_cmd_pkg::BUSY_BIT]; // RULE6
      act_pp <= wdata[sd_cmd_pkg::PUSH_PULL_BIT]; // RULE7
      act_data <= wdata[sd_cmd_pkg::DATA_BIT]; // RULE19
      act_stream <= wdata[sd_cmd_pkg::STREAM_BIT];
      act_dir <= wdata[sd_cmd_pkg::DIR_BIT];
    end
  end

  // Data transfer tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      data_active <= 1'b0;
      data_write <= 1'b0;
      data_stream <= 1'b0;
      bytes_left <= '0;
    end else if (cmd_done && act_data) begin
      data_write <= act_dir; // RULE3 RULE19
      data_stream <= act_stream; // RULE19
      bytes_left <= total_bytes; // RULE1
      data_active <= act_stream || (total_bytes != '0); // RULE1 RULE2
    end else if (cmd_done && data_active && data_stream && (act_index == sd_cmd_pkg::STOP_CMD_INDEX)) begin
      data_active <= 1'b0; // RULE2
    end else if (data_active && !data_stream && data_byte_strobe) begin
      bytes_left <= bytes_left - 28'h000_0001; // RULE1
      if (bytes_left == 28'h000_0001) begin
        data_active <= 1'b0; // RULE1
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      command_issue <= sd_cmd_pkg::RESET_WORD;
      command_argument <= sd_cmd_pkg::RESET_WORD; // RULE13
      block_size <= 12'h000;
      block_count <= sd_cmd_pkg::RESET_HALF;
    end else if (wr_en) begin
      case (addr)
        sd_cmd_pkg::OFS_CMD: begin
          command_issue <= wdata & sd_cmd_pkg::CMD_WR_MASK;
        end
        sd_cmd_pkg::OFS_ARG: begin
          command_argument <= wdata; // RULE13
        end
        sd_cmd_pkg::OFS_BLK_SIZE: begin
          block_size <= wdata[11:0];
        end
        sd_cmd_pkg::OFS_BLK_COUNT: begin
          block_count <= wdata[15:0];
        end
        default: begin
          block_size <= block_size;
        end
      endcase
    end
  end

  // Response capture beats a software write in one cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int w = 0; w < sd_cmd_pkg::RSP_WORDS; w++) begin
        response_words[w] <= sd_cmd_pkg::RESET_HALF;
      end
      response_index <= sd_cmd_pkg::RESET_BYTE;
    end else if (rx_last) begin
      if (long_rsp) begin
        response_index <= next_rx[sd_cmd_pkg::IDX_LSB_136 +: 8]; // RULE16 RULE18
        for (int w = 0; w < sd_cmd_pkg::RSP_WORDS; w++) begin
          response_words[w] <= next_rx[w * sd_cmd_pkg::WORD_W +: sd_cmd_pkg::WORD_W]; // RULE14 RULE15 RULE18
        end
      end else begin
        response_index <= next_rx[sd_cmd_pkg::IDX_LSB_48 +: 8]; // RULE16 RULE17
        response_words[7] <= next_rx[sd_cmd_pkg::W7_LSB_48 +: sd_cmd_pkg::WORD_W]; // RULE14 RULE17
        response_words[6] <= next_rx[sd_cmd_pkg::W6_LSB_48 +: sd_cmd_pkg::WORD_W]; // RULE17
        response_words[5][7:0] <= next_rx[7:0]; // RULE17
      end
    end else if (wr_en) begin
      for (int p = 0; p < sd_cmd_pkg::RSP_WORDS / 2; p++) begin
        if (addr == 8'(sd_cmd_pkg::OFS_RSP01 + 4 * p)) begin
          response_words[2 * p] <= wdata[15:0];
          response_words[2 * p + 1] <= wdata[31:16];
        end
      end
      if (addr == sd_cmd_pkg::OFS_RSP_INDEX) begin
        response_index <= wdata[7:0];
      end
    end
  end

  // Sticky status flags, write one to clear; a new event beats the clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rsp_done <= 1'b0;
      crc_err <= 1'b0;
      rsp_timeout <= 1'b0;
      cmd_sent <= 1'b0;
    end else begin
      if (rx_last) begin
        rsp_done <= 1'b1;
      end else if (wr_en && (addr == sd_cmd_pkg::OFS_STATUS) && wdata[sd_cmd_pkg::ST_RSP_DONE_BIT]) begin
        rsp_done <= 1'b0;
      end
      if (rx_last && !crc_ok) begin
        crc_err <= 1'b1; // RULE5
      end else if (wr_en && (addr == sd_cmd_pkg::OFS_STATUS) && wdata[sd_cmd_pkg::ST_CRC_ERR_BIT]) begin
        crc_err <= 1'b0;
      end
      if (wait_timeout || busy_timeout) begin
        rsp_timeout <= 1'b1;
      end else if (wr_en && (addr == sd_cmd_pkg::OFS_STATUS) && wdata[sd_cmd_pkg::ST_TIMEOUT_BIT]) begin
        rsp_timeout <= 1'b0;
      end
      if (tx_end) begin
        cmd_sent <= 1'b1;
      end else if (wr_en && (addr == sd_cmd_pkg::OFS_STATUS) && wdata[sd_cmd_pkg::ST_CMD_SENT_BIT]) begin
        cmd_sent <= 1'b0;
      end
    end
  end

  // Status word assembly
  always_comb begin
    status_word = sd_cmd_pkg::RESET_WORD;
    status_word[sd_cmd_pkg::ST_ACTIVE_BIT] = (state != sd_cmd_pkg::ST_IDLE);
    status_word[sd_cmd_pkg::ST_RSP_DONE_BIT] = rsp_done;
    status_word[sd_cmd_pkg::ST_CRC_ERR_BIT] = crc_err;
    status_word[sd_cmd_pkg::ST_TIMEOUT_BIT] = rsp_timeout;
    status_word[sd_cmd_pkg::ST_CARD_BUSY_BIT] = (state == sd_cmd_pkg::ST_BUSY);
    status_word[sd_cmd_pkg::ST_DATA_ACTIVE_BIT] = data_active;
    status_word[sd_cmd_pkg::ST_CMD_SENT_BIT] = cmd_sent;
  end

  // Read data stands one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= sd_cmd_pkg::RESET_WORD;
    end else if (rd_en) begin
      case (addr)
        sd_cmd_pkg::OFS_CMD: rdata <= command_issue;
        sd_cmd_pkg::OFS_ARG: rdata <= command_argument;
        sd_cmd_pkg::OFS_RSP01: rdata <= {response_words[1], response_words[0]};
        sd_cmd_pkg::OFS_RSP23: rdata <= {response_words[3], response_words[2]};
        sd_cmd_pkg::OFS_RSP45: rdata <= {response_words[5], response_words[4]};
        sd_cmd_pkg::OFS_RSP67: rdata <= {response_words[7], response_words[6]};
        sd_cmd_pkg::OFS_RSP_INDEX: rdata <= {24'h00_0000, response_index};
        sd_cmd_pkg::OFS_STATUS: rdata <= status_word;
        sd_cmd_pkg::OFS_BLK_SIZE: rdata <= {20'h0_0000, block_size};
        sd_cmd_pkg::OFS_BLK_COUNT: rdata <= {16'h0000, block_count};
        default: rdata <= sd_cmd_pkg::RESET_WORD;
      endcase
    end else begin
      rdata <= sd_cmd_pkg::RESET_WORD;
    end
  end
endmodule : sd_command_issue_response
`default_nettype wire

// ### verification/sd_command_issue_response_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module sd_cmd_checker (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  // Card link
  input wire logic card_clk,
  input wire logic cmd_out,
  input wire logic cmd_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic pp;
  logic issued;
  logic [1:0] ck;
  logic [3:0] since_fall;
  // Drive mode mirror and saturating count since a card clock fall
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pp <= 1'b0;
      issued <= 1'b0;
      ck <= 2'b00;
      since_fall <= 4'hf;
    end else begin
      if (wr_en && addr == sd_cmd_pkg::OFS_CMD) begin
        pp <= wdata[sd_cmd_pkg::PUSH_PULL_BIT];
        issued <= 1'b1;
      end
      ck <= {ck[0], card_clk};
      since_fall <= (ck == 2'b10) ? 4'h0 : since_fall + {3'h0, since_fall != 4'hf};
    end
  end
  property p_od; cmd_oe && !pp |-> !cmd_out; endproperty
  a_od: assert property (p_od) else $error("open drain drove high");
  property p_start; $rose(cmd_oe) |-> !cmd_out; endproperty
  a_start: assert property (p_start) else $error("frame start not low");
  property p_ppend; pp && $fell(cmd_oe) |-> $past(cmd_out); endproperty
  a_ppend: assert property (p_ppend) else $error("end bit not high");
  property p_oemin; $rose(cmd_oe) |-> cmd_oe [*8]; endproperty
  a_oemin: assert property (p_oemin) else $error("bit too short");
  property p_edge; $changed(cmd_oe) || $changed(cmd_out) |-> since_fall <= 4'h6; endproperty
  a_edge: assert property (p_edge) else $error("bit off card clock fall");
  property p_quiet; !issued |-> !cmd_oe; endproperty
  a_quiet: assert property (p_quiet) else $error("drive before command");
  property p_late; wr_en && addr == sd_cmd_pkg::OFS_CMD && !cmd_oe |=> !cmd_oe; endproperty
  a_late: assert property (p_late) else $error("drive too soon");
  property p_rzero; !$past(rd_en) |-> rdata == 32'h0; endproperty
  a_rzero: assert property (p_rzero) else $error("stray read data");
  c_pp: cover property ($rose(cmd_oe) && pp);
  c_od: cover property (cmd_oe && !pp);
  c_rd: cover property ($past(rd_en) && rdata != 32'h0);
endmodule : sd_cmd_checker
bind sd_command_issue_response sd_cmd_checker i_sd_cmd_checker (.clk, .nrst, .addr, .wdata, .wr_en, .rd_en,
  .rdata, .card_clk, .cmd_out, .cmd_oe);
`default_nettype wire

// ### verification/sd_card_model.sv
`timescale 1ns/1ns
`default_nettype none
module sd_card_model (
  // Link
  input wire logic card_clk,
  input wire logic line,
  // Bench reply
  input wire logic [135:0] rsp,
  input wire logic [7:0] rsp_len,
  // Seen frame, pull-down
  output logic [47:0] frame,
  output logic drv_low
);
  int cnt = 0;
  int tx = 0;
  initial frame = 48'h0;
  initial drv_low = 1'b0;
  // Command taken on rises, never our own reply
  always @(posedge card_clk) begin
    if (tx == 0 && (cnt > 0 || line === 1'b0)) begin
      frame = {frame[46:0], line};
      cnt = cnt + 1;
      if (cnt == 48) begin
        cnt = 0;
        tx = rsp_len + 2;
      end
    end
  end
  // Reply MSB first on falls after one idle clock; pull-up makes ones
  always @(negedge card_clk) begin
    if (tx > 0) tx = tx - 1;
    drv_low = tx > 0 && tx <= rsp_len && !rsp[tx - 1];
  end
endmodule : sd_card_model
`default_nettype wire

// ### verification/sd_command_issue_response_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module sd_command_issue_response_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic card_clk = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic strobe = 1'b0;
  logic dat0 = 1'b1;
  logic [31:0] rdata;
  logic cmd_out, cmd_oe, data_active, data_write, data_stream, drv_low, line;
  logic [47:0] frame;
  logic [135:0] rsp = 136'h0;
  logic [7:0] rsp_len = 8'h00;
  int miscompares = 0;
  int n_tests = 0;
  // Pulled-up line, pulled low by either side
  assign line = (cmd_oe ? cmd_out : 1'b1) & !drv_low;
  initial forever #2 clk = ~clk;
  initial begin
    #3;
    forever #32 card_clk = ~card_clk;
  end
  sd_command_issue_response #(.BUSY_MAX_CLKS(20)) i_sd_command_issue_response (.clk, .nrst, .addr, .wdata,
    .wr_en, .rd_en, .rdata, .card_clk, .cmd_in(line), .cmd_out, .cmd_oe, .dat0_in(dat0),
    .data_byte_strobe(strobe), .data_active, .data_write, .data_stream);
  sd_card_model i_sd_card_model (.card_clk, .line, .rsp, .rsp_len, .frame, .drv_low);
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  function automatic logic [6:0] crc7(input logic [119:0] d, input int n);
    logic [6:0] c;
    c = 7'h00;
    for (int i = n - 1; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((d[i] ^ c[6]) ? 7'h09 : 7'h00);
    return c;
  endfunction : crc7
  // One command and reply; check frame, reply and kept registers
  task automatic issue(input logic [5:0] idx, input logic [1:0] k, input logic [15:0] fl, input logic bad);
    logic [31:0] a, v, c;
    logic [127:0] b;
    logic [135:0] r;
    a = {2'h1, idx, 8'h5a, ~idx, 2'h2, idx[3:0], 4'h9};
    c = {16'h0, fl | {5'h0, k, 3'h0, idx}};
    b = (k == 2'h2) ? {8'h3f, {4{a[29:0]}}} : {88'h0, 2'h0, idx, ~a};
    r = {b, crc7(b[119:0], (k == 2'h2) ? 120 : 40) ^ {7{bad}}, 1'b1};
    rsp <= r;
    rsp_len <= (k == 2'h0) ? 8'h00 : (k == 2'h2) ? 8'h88 : 8'h30;
    wr(sd_cmd_pkg::OFS_ARG, a);
    wr(sd_cmd_pkg::OFS_CMD, c);
    v = 32'h1;
    for (int i = 0; i < 3000 && v[0]; i++) rd(sd_cmd_pkg::OFS_STATUS, v);
    `CHK("frame", {2'h1, idx, a, crc7({80'h0, 2'h1, idx, a}, 40), 1'b1}, frame)
    `CHK("crc_err", bad && k != 2'h3, v[2])
    `CHK("rsp_done", k != 2'h0, v[1])
    if (k != 2'h0) begin
      rd(sd_cmd_pkg::OFS_RSP_INDEX, v);
      `CHK("index", r[((k == 2'h2) ? 135 : 47) -: 8], v[7:0])
      for (int i = 0; i < 4; i++) begin
        rd(sd_cmd_pkg::OFS_RSP01 + 8'(4 * i), v);
        if (k == 2'h2) `CHK("words", r[32 * i +: 32], v)
      end
      if (k != 2'h2) `CHK("w7w6", r[39:8], v)
      rd(sd_cmd_pkg::OFS_RSP45, v);
      if (k != 2'h2) `CHK("w5", r[7:0], v[23:16])
    end
    rd(sd_cmd_pkg::OFS_CMD, v);
    `CHK("cmd", c, v)
    rd(sd_cmd_pkg::OFS_ARG, v);
    `CHK("arg", a, v)
    wr(sd_cmd_pkg::OFS_STATUS, 32'h0000_004e);
  endtask : issue
  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : finish_test
  // Eight commands fit well inside
  initial begin
    #300000;
    miscompares++;
    finish_test();
  end
  initial begin
    logic [31:0] v;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    // Register reset values, 0x28 unmapped
    for (int i = 0; i < 11; i++) begin
      rd(8'(4 * i), v);
      `CHK("reset", 32'h0, v)
    end
    issue(6'h02, 2'h2, 16'h0000, 1'b1);
    issue(6'h11, 2'h1, 16'h0080, 1'b0);
    issue(6'h29, 2'h3, 16'h0000, 1'b1);
    issue(6'h3f, 2'h0, 16'h0080, 1'b0);
    issue(6'h07, 2'h1, 16'h0100, 1'b0);
    wr(sd_cmd_pkg::OFS_BLK_SIZE, 32'h2);
    wr(sd_cmd_pkg::OFS_BLK_COUNT, 32'h1);
    issue(6'h19, 2'h1, 16'h2800, 1'b0);
    `CHK("block", 3'b110, {data_active, data_write, data_stream})
    // Two bytes end a two-byte block, not one
    for (int i = 1; i >= 0; i--) begin
      @(posedge clk);
      strobe <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
      repeat (2) @(posedge clk);
      #1 `CHK("active", i[0], data_active)
    end
    issue(6'h12, 2'h1, 16'h3000, 1'b0);
    `CHK("stream", 3'b101, {data_active, data_write, data_stream})
    issue(sd_cmd_pkg::STOP_CMD_INDEX, 2'h1, 16'h0000, 1'b0);
    `CHK("stopped", 1'b0, data_active)
    finish_test();
  end
endmodule : sd_command_issue_response_tb_top
`default_nettype wire
